// File: rtl/sync3.sv
// Three-stage synchroniser; a change counts when stages two and three agree.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module sync3 (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Signal.
    input wire logic d,
    output logic q
);
    logic [2:0] s_r;
    logic [2:0] s_nxt;
    logic q_r;
    logic q_nxt;

    // Shift in; update the output only when the last two stages agree.
    always_comb begin
        s_nxt = {s_r[1:0], d};
        q_nxt = (s_r[1] == s_r[2]) ? s_r[2] : q_r;
    end

    // Registers only.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_r <= 3'h0;
            q_r <= 1'b0;
        end else begin
            s_r <= s_nxt;
            q_r <= q_nxt;
        end
    end

    assign q = q_r;
endmodule // sync3
`default_nettype wire

// File: rtl/trim_link.sv
// Serial-clock side of calibration: shifts the command, counts 65 edges.
// Assumes the host keeps chip select high for the whole trim sequence.
`timescale 1ns/1ps
`default_nettype none
module trim_link
    import wake_rtc_pkg::*;
(
    // Link clock and chip select (select acts as the link's reset).
    input wire logic sclk,
    input wire logic chip_select,
    // System reset, which only clears the completion toggle.
    input wire logic rst_n,
    // Serial data.
    input wire logic serial_data_in,
    // Toggles once each time a calibration completes.
    output logic done_tgl
);
    logic [7:0] sh_r;
    logic [7:0] sh_nxt;
    logic [3:0] bits_r;
    logic [3:0] bits_nxt;
    logic [6:0] edges_r;
    logic [6:0] edges_nxt;
    logic arm_r;
    logic arm_nxt;
    logic tgl_r;
    logic tgl_nxt;

    // Command is taken after eight bits; then reference edges are counted.
    always_comb begin
        sh_nxt = sh_r;
        bits_nxt = bits_r;
        edges_nxt = edges_r;
        arm_nxt = arm_r;
        tgl_nxt = tgl_r;
        if (bits_r != 4'h8) begin
            sh_nxt = {sh_r[6:0], serial_data_in};
            bits_nxt = bits_r + 4'h1;
        end else if (sh_r == TRIM_CMD && !arm_r) begin
            arm_nxt = 1'b1;
            // The edge that arms is already the first reference edge.
            edges_nxt = 7'h01;
        end
        if (arm_r && edges_r != TRIM_EDGES) begin
            edges_nxt = edges_r + 7'h01;
            if (edges_r + 7'h01 == TRIM_EDGES) begin
                tgl_nxt = ~tgl_r;
            end
        end
    end

    // Deselect clears the frame; toggle survives for the crossing.
    always_ff @(posedge sclk or negedge chip_select) begin
        if (!chip_select) begin
            sh_r <= 8'h00;
            bits_r <= 4'h0;
            edges_r <= 7'h00;
            arm_r <= 1'b0;
        end else begin
            sh_r <= sh_nxt;
            bits_r <= bits_nxt;
            edges_r <= edges_nxt;
            arm_r <= arm_nxt;
        end
    end

    // The toggle ignores select, so a finished trim is not lost; only the
    // system reset clears it, while the link clock stands still.
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            tgl_r <= 1'b0;
        end else begin
            tgl_r <= tgl_nxt;
        end
    end

    assign done_tgl = tgl_r;
endmodule // trim_link
`default_nettype wire

// File: rtl/wake_rtc_ctrl.sv
// Wake-up support: false wake counter, clock source, RC trim and mode check.
// Assumes pulses from the detector are on clk; serial link on its own clock.
// Behaviour
// - Frequency hit without valid pattern adds one to the false wake count.
// - Select one runs time base from crystal or external; zero from RC.
// - Calibration starts only on the oscillator trim serial command.
// - RC off in power down, reset or crystal; trim lost, redo it.
// - New trim applies only after the sixty-fifth reference edge.
// - Over-long carrier burst drops wake-up and adds one to the count.
`timescale 1ns/1ps
`default_nettype none
module wake_rtc_ctrl
    import wake_rtc_pkg::*;
(
    // System clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Serial control link.
    input wire logic sclk,
    input wire logic chip_select,
    input wire logic serial_data_in,
    // Detector events.
    input wire logic freq_detect,
    input wire logic pattern_ok,
    input wire logic burst_too_long,
    // Configuration.
    input wire logic clock_source_select,
    input wire logic power_down,
    input wire logic [2:0] chan_en,
    input wire logic scan_mode,
    input wire logic onoff_mode,
    input wire logic [6:0] trim_measured,
    // Status.
    output logic [7:0] false_wake_count,
    output logic internal_wake,
    output logic rc_osc_on,
    output logic use_crystal,
    output logic [6:0] rc_trim,
    output logic trim_valid,
    output logic illegal_cfg
);
    ////////////////////////////////////////////////////////////////////////
    // Link side and crossing of the completion toggle.
    logic done_tgl;
    logic done_s;
    logic done_d_r;

    trim_link u_link (
        .sclk(sclk),
        .chip_select(chip_select),
        .rst_n(rst_n),
        .serial_data_in(serial_data_in),
        .done_tgl(done_tgl)
    );

    sync3 u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(done_tgl),
        .q(done_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // State and next values.
    logic [7:0] count_r;
    logic [7:0] count_nxt;
    logic wake_r;
    logic wake_nxt;
    logic pend_r;
    logic pend_nxt;
    logic rc_on_r;
    logic rc_on_nxt;
    logic xtal_r;
    logic xtal_nxt;
    logic [6:0] trim_r;
    logic [6:0] trim_nxt;
    logic tv_r;
    logic tv_nxt;
    logic ill_r;
    logic ill_nxt;
    logic done_d_nxt;

    // Two enabled channels with a low-power mode must be 1 and 3.
    function automatic logic bad_mode(input logic [2:0] en, input logic sc,
                                      input logic oo);
        logic [1:0] n;
        n = 2'(en[0]) + 2'(en[1]) + 2'(en[2]);
        bad_mode = (sc && oo)
            || ((sc || oo) && n == 2'h2 && en != 3'b101)
            || (oo && n == 2'h1 && en != 3'b001);
    endfunction

    // Wake tracking: a frequency hit arms; pattern or failure resolves it.
    // A pattern in the same cycle as the hit counts as valid.
    always_comb begin
        count_nxt = count_r;
        wake_nxt = wake_r;
        pend_nxt = pend_r;
        if (freq_detect && !pattern_ok) begin
            pend_nxt = 1'b1;
            wake_nxt = 1'b1;
        end
        if (pattern_ok) begin
            pend_nxt = 1'b0;
        end
        if (burst_too_long && wake_r) begin
            wake_nxt = 1'b0;
            pend_nxt = 1'b0;
            count_nxt = count_r + 8'h01;
        end else if (pend_r && !freq_detect && !pattern_ok) begin
            // Frequency passed, signal gone, no pattern: false wake-up.
            pend_nxt = 1'b0;
            wake_nxt = 1'b0;
            count_nxt = count_r + 8'h01;
        end
    end

    // Clock source, oscillator power and trim storage.
    always_comb begin
        done_d_nxt = done_s;
        xtal_nxt = (clock_source_select == SRC_XTAL);
        rc_on_nxt = !power_down && !xtal_nxt;
        trim_nxt = trim_r;
        tv_nxt = tv_r;
        if (done_s != done_d_r && rc_on_r) begin
            trim_nxt = trim_measured;
            tv_nxt = 1'b1;
        end
        if (!rc_on_r) begin
            // Volatile trim: lost whenever the oscillator stops.
            trim_nxt = TRIM_RESET;
            tv_nxt = 1'b0;
        end
        ill_nxt = bad_mode(chan_en, scan_mode, onoff_mode);
    end

    // Registers only; synchronous reset also acts as power-on reset.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_r <= FALSE_RESET;
            wake_r <= 1'b0;
            pend_r <= 1'b0;
            rc_on_r <= 1'b0;
            xtal_r <= SRC_RC;
            trim_r <= TRIM_RESET;
            tv_r <= 1'b0;
            ill_r <= 1'b0;
            done_d_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            wake_r <= wake_nxt;
            pend_r <= pend_nxt;
            rc_on_r <= rc_on_nxt;
            xtal_r <= xtal_nxt;
            trim_r <= trim_nxt;
            tv_r <= tv_nxt;
            ill_r <= ill_nxt;
            done_d_r <= done_d_nxt;
        end
    end

    // Outputs straight from flip-flops.
    assign false_wake_count = count_r;
    assign internal_wake = wake_r;
    assign rc_osc_on = rc_on_r;
    assign use_crystal = xtal_r;
    assign rc_trim = trim_r;
    assign trim_valid = tv_r;
    assign illegal_cfg = ill_r;
endmodule // wake_rtc_ctrl
`default_nettype wire

// File: rtl/wake_rtc_pkg.sv
// Package for the wake-up support block: time base, trim, false wake count.
// Assumes a 10 MHz system clock and a serial clock from the host.
`default_nettype none
package wake_rtc_pkg;
    // Serial command width and the trim command code.
    localparam int CMD_W = 8;
    localparam logic [7:0] TRIM_CMD = 8'h11;
    // Reference edges that make up one calibration.
    localparam logic [6:0] TRIM_EDGES = 7'h41;
    // Width of the trim word, and its reset value (untrimmed centre).
    localparam int TRIM_W = 7;
    localparam logic [6:0] TRIM_RESET = 7'h40;
    // False wake count reset value.
    localparam logic [7:0] FALSE_RESET = 8'h00;
    // Clock source select encodings.
    localparam logic SRC_RC = 1'b0;
    localparam logic SRC_XTAL = 1'b1;
endpackage
`default_nettype wire

// File: testbench/host_serial_model.sv
// Host side of the serial link: sends commands and reference edges.
// Assumes an 8 MHz link clock that stands still low between frames.
`timescale 1ns/1ps
`default_nettype none
module host_serial_model (
    // Serial link.
    output logic sclk,
    output logic chip_select,
    output logic serial_data_in
);
    initial begin
        sclk = 1'b0;
        chip_select = 1'b0;
        serial_data_in = 1'b0;
    end
    // Select, command MSB first, reference edges, deselect.
    // The 125 ns link period stands in for the reference rate.
    task automatic frame(input logic [7:0] cmd, input int edges);
        chip_select = 1'b1;
        #37;
        for (int i = 7; i >= 0; i--) begin
            serial_data_in = cmd[i];
            #62.5 sclk = 1'b1;
            #62.5 sclk = 1'b0;
        end
        // The released data line shows the inverse, never a stale bit.
        serial_data_in = ~cmd[0];
        repeat (edges) begin
            #62.5 sclk = 1'b1;
            #62.5 sclk = 1'b0;
        end
        #60 chip_select = 1'b0;
    endtask
endmodule // host_serial_model
`default_nettype wire

// File: testbench/wake_rtc_ctrl_properties.sv
// Checker for the wake-up support block, bound to its ports.
// Assumes one clock domain on clk with synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module wake_rtc_ctrl_properties (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Inputs watched.
    input wire logic freq_detect,
    input wire logic pattern_ok,
    input wire logic burst_too_long,
    input wire logic clock_source_select,
    input wire logic power_down,
    input wire logic [2:0] chan_en,
    input wire logic scan_mode,
    input wire logic onoff_mode,
    input wire logic [6:0] trim_measured,
    // Outputs watched.
    input wire logic [7:0] false_wake_count,
    input wire logic internal_wake,
    input wire logic rc_osc_on,
    input wire logic use_crystal,
    input wire logic [6:0] rc_trim,
    input wire logic trim_valid,
    input wire logic illegal_cfg
);
    // All checks share the system clock and its reset.
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_SRC: assert property ($past(rst_n) |->
        use_crystal == $past(clock_source_select)) else $error("source");
    AST_RC_OFF: assert property ($past(rst_n) |-> rc_osc_on ==
        $past(!power_down && !clock_source_select)) else $error("rc on");
    AST_FALSE: assert property (freq_detect && !pattern_ok &&
        !burst_too_long ##1 !freq_detect && !pattern_ok &&
        !burst_too_long |=> false_wake_count ==
        $past(false_wake_count) + 8'h01) else $error("false wake");
    AST_BURST: assert property (internal_wake && freq_detect &&
        burst_too_long |=> !internal_wake && false_wake_count ==
        $past(false_wake_count) + 8'h01) else $error("burst");
    AST_HOLD: assert property (!internal_wake |=>
        $stable(false_wake_count)) else $error("count moved");
    AST_BOTH: assert property (scan_mode && onoff_mode |=>
        illegal_cfg) else $error("both modes");
    AST_ONE: assert property (onoff_mode && !scan_mode &&
        chan_en == 3'h2 |=> illegal_cfg) else $error("one channel");
    AST_TWO: assert property (scan_mode && !onoff_mode &&
        chan_en == 3'h5 |=> !illegal_cfg) else $error("two channels");
    AST_LOST: assert property ((power_down || clock_source_select)
        [*2] |=> !trim_valid) else $error("trim kept");
    AST_TRIM: assert property ($rose(trim_valid) |->
        rc_trim == trim_measured) else $error("trim value");
endmodule // wake_rtc_ctrl_properties
bind wake_rtc_ctrl wake_rtc_ctrl_properties chk_i (.clk, .rst_n,
    .freq_detect, .pattern_ok, .burst_too_long, .clock_source_select,
    .power_down, .chan_en, .scan_mode, .onoff_mode, .trim_measured,
    .false_wake_count, .internal_wake, .rc_osc_on, .use_crystal,
    .rc_trim, .trim_valid, .illegal_cfg);
`default_nettype wire

// File: testbench/wake_rtc_ctrl_tb.sv
// Self-checking bench for the wake-up support block.
// Assumes the host model drives the link; inputs change on falling clk.
`timescale 1ns/1ps
`default_nettype none
module wake_rtc_ctrl_tb;
    import wake_rtc_pkg::*;
    logic clk, rst_n, sclk, chip_select, serial_data_in, freq_detect;
    logic pattern_ok, burst_too_long, clock_source_select, power_down;
    logic scan_mode, onoff_mode, internal_wake, rc_osc_on, use_crystal;
    logic trim_valid, illegal_cfg;
    logic [2:0] chan_en;
    logic [6:0] trim_measured, rc_trim;
    logic [7:0] false_wake_count;
    int n_mismatch = 0;
    int compares = 0;
    // Mode table entries: scan, on/off, channels, expected flag.
    logic [5:0] modes [7] = '{6'h3F, 6'h15, 6'h12, 6'h27, 6'h2A, 6'h1D,
        6'h06};
    host_serial_model host (.sclk, .chip_select, .serial_data_in);
    wake_rtc_ctrl uut (.clk, .rst_n, .sclk, .chip_select, .serial_data_in,
        .freq_detect, .pattern_ok, .burst_too_long, .clock_source_select,
        .power_down, .chan_en, .scan_mode, .onoff_mode, .trim_measured,
        .false_wake_count, .internal_wake, .rc_osc_on, .use_crystal,
        .rc_trim, .trim_valid, .illegal_cfg);
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // A hang is cut short well beyond the expected run of about 38 us.
    initial begin
        #1000000;
        n_mismatch++;
        end_sim;
    end
    initial begin
        // Let every design process start before reset falls.
        #1;
        {rst_n, freq_detect, pattern_ok, burst_too_long} = '0;
        {clock_source_select, power_down, scan_mode, onoff_mode} = '0;
        chan_en = 3'h7;
        trim_measured = 7'h2A;
        tick(2);
        rst_n = 1'b1;
        tick(4);
        chk(false_wake_count, FALSE_RESET);
        chk(8'(rc_trim), 8'h40);
        clock_source_select = 1'b1;
        tick(2);
        chk(8'({use_crystal, rc_osc_on}), 8'h02);
        clock_source_select = 1'b0;
        power_down = 1'b1;
        tick(2);
        chk(8'({use_crystal, rc_osc_on}), 8'h00);
        power_down = 1'b0;
        tick(2);
        chk(8'({use_crystal, rc_osc_on}), 8'h01);
        for (int i = 1; i <= 3; i++) begin
            freq_detect = 1'b1;
            tick(1);
            freq_detect = 1'b0;
            tick(2);
            chk(false_wake_count, 8'(i));
        end
        // A valid pattern and a lone burst both leave the count alone.
        {freq_detect, pattern_ok} = 2'h3;
        tick(1);
        {freq_detect, pattern_ok, burst_too_long} = 3'h1;
        tick(1);
        burst_too_long = 1'b0;
        tick(2);
        chk(false_wake_count, 8'h03);
        freq_detect = 1'b1;
        tick(1);
        burst_too_long = 1'b1;
        tick(1);
        {freq_detect, burst_too_long} = 2'h0;
        chk({internal_wake, false_wake_count[6:0]}, 8'h04);
        host.frame(8'h22, 65);
        tick(20);
        chk(8'(trim_valid), 8'h00);
        host.frame(TRIM_CMD, 64);
        tick(20);
        chk(8'(trim_valid), 8'h00);
        host.frame(TRIM_CMD, 65);
        tick(20);
        chk({trim_valid, rc_trim}, 8'hAA);
        clock_source_select = 1'b1;
        tick(4);
        chk({trim_valid, rc_trim}, 8'h40);
        clock_source_select = 1'b0;
        for (int i = 0; i < 7; i++) begin
            {scan_mode, onoff_mode, chan_en} = modes[i][5:1];
            tick(2);
            chk(8'(illegal_cfg), 8'(modes[i][0]));
        end
        end_sim;
    end
endmodule // wake_rtc_ctrl_tb
`default_nettype wire
